// *** dstc_dram_model.sv ***
`timescale 1ns/10ps
module dstc_dram_model (
    input  wire logic       row_strobe,
    input  wire logic       bank0_row_select,
    input  wire logic       bank1_row_select,
    output logic      [1:0] bank_row_n
);
    // only the selected bank sees the strobe; idle banks stay high
    assign bank_row_n = ~({bank1_row_select, bank0_row_select} & {2{row_strobe}});
endmodule

// *** dstc_pkg.sv ***
package dstc_pkg;
    // cycle counts in mclk cycles from the row strobe rise
    localparam int unsigned ROW_HOLD_ZERO_WS = 2;
    localparam int unsigned ROW_HOLD_ONE_WS  = 3;
    localparam int unsigned COL_DELAY_ZERO   = 1;
    localparam int unsigned CNT_W            = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 3'h0;
    typedef enum logic [1:0] {
        DSTC_IDLE,
        DSTC_MEM,
        DSTC_REFRESH
    } dstc_state_t;
endpackage

// *** dstc_sync.sv ***
`timescale 1ns/10ps
module dstc_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // meta is read only by q
    always_ff @(posedge mclk) begin
        if (reset) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// *** dstc_top.sv ***
`timescale 1ns/10ps
module dstc_top
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic mem_status,
    input  wire logic write_status,
    input  wire logic cycle_end,
    input  wire logic write_wait_select,
    input  wire logic read_wait_select,
    input  wire logic hold_acknowledge_in,
    input  wire logic refresh_n,
    output logic      row_strobe,
    output logic      col_strobe,
    output logic      early_write_enable_n
);
    import dstc_pkg::*;

    logic [3:0]       pins;
    logic             wws_s;
    logic             rws_s;
    logic             hlda_s;
    logic             refresh_req_s;
    logic             refresh_prev;
    dstc_state_t      state;
    logic             one_wait;
    logic [CNT_W-1:0] cnt;
    logic             col_half;
    logic             col_fall;
    logic             refresh_start;

    // straps and refresh come from pins: two flops first
    // refresh goes in inverted so the synced reset value is the idle level
    dstc_sync #(.W(4)) u_sync (
        .mclk  (mclk),
        .reset (reset),
        .d     ({write_wait_select, read_wait_select, hold_acknowledge_in, ~refresh_n}),
        .q     (pins)
    );
    assign wws_s         = pins[3];
    assign rws_s         = pins[2];
    assign hlda_s        = pins[1];
    assign refresh_req_s = pins[0];

    always_ff @(posedge mclk) begin
        if (reset) begin
            refresh_prev <= 1'b0;
        end else begin
            refresh_prev <= refresh_req_s;
        end
    end
    assign refresh_start = refresh_req_s && !refresh_prev;

    // cycle state; mem_status marks the second phase of a status cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= DSTC_IDLE;
        end else begin
            case (state)
                DSTC_IDLE: begin
                    if (refresh_start) begin
                        state <= DSTC_REFRESH;
                    end else if (mem_status && !hlda_s) begin
                        state <= DSTC_MEM;
                    end
                end
                DSTC_MEM: begin
                    if (cycle_end) begin
                        state <= DSTC_IDLE;
                    end
                end
                DSTC_REFRESH: begin
                    if (cycle_end) begin
                        state <= DSTC_IDLE;
                    end
                end
                default: state <= DSTC_IDLE;
            endcase
        end
    end

    // wait selection latched at the cycle start
    always_ff @(posedge mclk) begin
        if (reset) begin
            one_wait <= 1'b0;
        end else if (state == DSTC_IDLE && refresh_start) begin
            one_wait <= rws_s;
        end else if (state == DSTC_IDLE && mem_status) begin
            one_wait <= write_status ? wws_s : rws_s;
        end
    end

    // cycles since row strobe rise
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt <= CNT_ZERO;
        end else if (state == DSTC_IDLE) begin
            cnt <= CNT_ZERO;
        end else if (cnt != {CNT_W{1'b1}}) begin
            cnt <= cnt + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            row_strobe <= 1'b0;
        end else if (state == DSTC_IDLE) begin
            row_strobe <= (mem_status && !hlda_s) || refresh_start;
        end else if (cnt == CNT_W'(one_wait ? ROW_HOLD_ONE_WS - 1 : ROW_HOLD_ZERO_WS - 1)) begin
            row_strobe <= 1'b0;
        end
    end

    // half-clock placement uses a falling-edge flop; trades one negedge flop for exact timing
    always_ff @(posedge mclk) begin
        if (reset) begin
            col_half <= 1'b0;
        end else if (state != DSTC_MEM || cycle_end) begin
            col_half <= 1'b0;
        end else if (cnt == CNT_W'(COL_DELAY_ZERO - 1)) begin
            col_half <= 1'b1;
        end
    end

    always_ff @(negedge mclk) begin
        if (reset) begin
            col_fall <= 1'b0;
        end else begin
            col_fall <= col_half && one_wait && state == DSTC_MEM;
        end
    end

    always_comb begin
        if (one_wait) begin
            col_strobe = col_fall && col_half;
        end else begin
            col_strobe = col_half;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            early_write_enable_n <= 1'b1;
        end else if (state == DSTC_IDLE) begin
            early_write_enable_n <= !(mem_status && write_status && !hlda_s
                                      && !refresh_start);
        end else if (cycle_end) begin
            early_write_enable_n <= 1'b1;
        end
    end

    row_fall_a: assert property (@(posedge mclk) disable iff (reset)
        $rose(row_strobe) && !one_wait |-> row_strobe[*2] ##1 !row_strobe)
        else $error("row strobe zero wait width wrong");

    row_one_a: assert property (@(posedge mclk) disable iff (reset)
        $rose(row_strobe) && one_wait |-> row_strobe[*3] ##1 !row_strobe)
        else $error("row strobe one wait width wrong");

    // negedge sampling tells the whole and the half clock placement apart
    col_zero_a: assert property (@(negedge mclk) disable iff (reset)
        $rose(row_strobe) && !one_wait && state == DSTC_MEM |-> !col_strobe ##1 col_strobe)
        else $error("column strobe zero wait placement wrong");

    col_one_a: assert property (@(negedge mclk) disable iff (reset)
        $rose(row_strobe) && one_wait && state == DSTC_MEM |-> !col_strobe[*2] ##1 col_strobe)
        else $error("column strobe one wait placement wrong");

    col_end_a: assert property (@(posedge mclk) disable iff (reset)
        cycle_end |=> !col_strobe)
        else $error("column strobe not low after cycle end");

    ewe_set_a: assert property (@(posedge mclk) disable iff (reset)
        state == DSTC_IDLE && mem_status && write_status && !hlda_s && !refresh_start
        |=> !early_write_enable_n)
        else $error("early write enable not asserted");

    ewe_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !early_write_enable_n && !cycle_end |=> !early_write_enable_n)
        else $error("early write enable released early");

    ewe_end_a: assert property (@(posedge mclk) disable iff (reset)
        cycle_end && state != DSTC_IDLE |=> early_write_enable_n && state == DSTC_IDLE)
        else $error("early write enable not released at cycle end");

    wait_wr_a: assert property (@(posedge mclk) disable iff (reset)
        state == DSTC_IDLE && mem_status && write_status && !refresh_start
        |=> one_wait == $past(wws_s))
        else $error("write cycle wait choice not from write select");

    wait_rd_a: assert property (@(posedge mclk) disable iff (reset)
        state == DSTC_IDLE && mem_status && !write_status && !refresh_start
        |=> one_wait == $past(rws_s))
        else $error("read cycle wait choice not from read select");

    hold_block_a: assert property (@(posedge mclk) disable iff (reset)
        state == DSTC_IDLE && hlda_s && !refresh_start |=> state == DSTC_IDLE && !row_strobe)
        else $error("memory cycle started during hold");

    refresh_go_a: assert property (@(posedge mclk) disable iff (reset)
        state == DSTC_IDLE && refresh_start |=> state == DSTC_REFRESH && row_strobe)
        else $error("refresh cycle not started");

    refresh_quiet_a: assert property (@(posedge mclk) disable iff (reset)
        state == DSTC_REFRESH |-> early_write_enable_n && !col_strobe)
        else $error("write or column strobe active in refresh");

    idle_low_a: assert property (@(posedge mclk) disable iff (reset)
        state == DSTC_IDLE && $past(state) == DSTC_IDLE
        |-> !row_strobe && !col_strobe && early_write_enable_n)
        else $error("strobe active while idle");
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import dstc_pkg::*;
    logic        mclk = 1'h0;
    logic        reset = 1'h1;
    logic        mem_status = 1'h0;
    logic        write_status = 1'h0;
    logic        cycle_end = 1'h0;
    logic        write_wait_select = 1'h0;
    logic        read_wait_select = 1'h0;
    logic        hold_acknowledge_in = 1'h0;
    logic        refresh_n = 1'h1;
    logic        bank0_row_select = 1'h0;
    logic        bank1_row_select = 1'h0;
    logic        row_strobe, col_strobe, early_write_enable_n, ew;
    logic        prow = 1'h0;
    logic [1:0]  bank_row_n;
    logic [31:0] seed = 32'h00012dec;
    logic [7:0]  q[$];
    int          err_total = 0, check_count = 0, cyc = 0, hc = 0, cd = 0;
    always #12.5 mclk = ~mclk;
    dstc_top i_dstc_top (.mclk(mclk), .reset(reset), .mem_status(mem_status),
        .write_status(write_status), .cycle_end(cycle_end),
        .write_wait_select(write_wait_select), .read_wait_select(read_wait_select),
        .hold_acknowledge_in(hold_acknowledge_in), .refresh_n(refresh_n),
        .row_strobe(row_strobe), .col_strobe(col_strobe),
        .early_write_enable_n(early_write_enable_n));
    dstc_dram_model i_dstc_dram_model (.row_strobe(row_strobe),
        .bank0_row_select(bank0_row_select), .bank1_row_select(bank1_row_select),
        .bank_row_n(bank_row_n));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_lvl(input logic [4:0] exp);
        check_count++;
        if ({bank_row_n, row_strobe, col_strobe, early_write_enable_n} !== exp) begin
            err_total++;
            $display("Error at %0t: levels %b expected %b", $time,
                {bank_row_n, row_strobe, col_strobe, early_write_enable_n}, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // half-cycle timing of each strobe, measured from the row rise
    always @(mclk) begin
        #1;
        if (row_strobe && !prow) begin
            hc = 0;
            cd = 0;
            ew = early_write_enable_n;
        end else if (row_strobe) hc++;
        if (col_strobe && row_strobe && cd == 0) cd = hc;
        if (!row_strobe && prow) begin
            if (q.size() == 0) cmp(8'hff, 8'h00);
            else cmp({ew, cd[2:0], 4'(hc + 1)}, q.pop_front());
        end
        prow = row_strobe;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            conclude();
        end
    end
    // wait pins are synced, so they settle well before the status
    task automatic run(input logic wr, input logic wt, input logic rfr, input logic hd);
        @(posedge mclk);
        write_wait_select <= wr ? wt : ~wt;
        read_wait_select <= wr ? ~wt : wt;
        hold_acknowledge_in <= hd;
        bank0_row_select <= seed[3];
        bank1_row_select <= ~seed[3];
        repeat (4) @(posedge mclk);
        // refresh runs whether or not hold is acknowledged
        if (!hd || rfr) q.push_back({~wr, rfr ? 3'h0 : (wt ? 3'h3 : 3'h2), wt ? 4'h6 : 4'h4});
        if (rfr) refresh_n <= 1'h0;
        else mem_status <= 1'h1;
        write_status <= wr;
        @(posedge mclk);
        mem_status <= 1'h0;
        repeat (9) @(posedge mclk);
        @(negedge mclk);
        cmp_lvl({3'h6, ~rfr & ~hd, ~wr | hd});
        @(posedge mclk);
        cycle_end <= 1'h1;
        refresh_n <= 1'h1;
        @(posedge mclk);
        cycle_end <= 1'h0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        cmp_lvl(5'h19);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'h0;
        repeat (3) @(posedge mclk);
        #1;
        cmp_lvl(5'h19);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            run(i < 4 ? i[0] : seed[0], i < 4 ? i[1] : seed[1], i % 6 == 5 && !seed[0],
                i % 8 == 7);
        end
        cmp(8'(q.size()), 8'h00);
        conclude();
    end
endmodule
